// ---- core/gscm_pkg.sv ----
// What this block does
// - Every standard command carries one two-byte data word.
// - Commands use code pairs from 0x00/0x01 up to 0x2C/0x2D.
// - Control writable always, rate setpoint only when open, rest read-only.
// - Standard commands are served in every power mode.
// - 64 bytes of user flash as two 32-byte blocks via a port.
// - Direct flash writes are refused unless access is opened.
// - Host reads and writes registers over the serial bus.
// - Power mode moves among normal, sleep, hibernate and insertion probe.
// - Host can read charge percent, time to empty and time to full.
// - Temperature comes from the thermistor unless internal sensor selected.
// - Low byte sits at the even code, high byte at the odd one.
package gscm_pkg;

   // Serial bus slave address (7 bit)
   localparam logic [6:0]  SLAVE_ADDR       = 7'h55;
   localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;

   // Command code offsets of the standard command pairs
   localparam logic [7:0]  OFS_CONTROL      = 8'h00;
   localparam logic [7:0]  OFS_RATE         = 8'h02;
   localparam logic [7:0]  OFS_RATE_RUN     = 8'h04;
   localparam logic [7:0]  OFS_TEMP         = 8'h06;
   localparam logic [7:0]  OFS_VOLT         = 8'h08;
   localparam logic [7:0]  OFS_FLAGS        = 8'h0A;
   localparam logic [7:0]  OFS_NOM_CAP      = 8'h0C;
   localparam logic [7:0]  OFS_FULL_AVAIL   = 8'h0E;
   localparam logic [7:0]  OFS_REMAIN       = 8'h10;
   localparam logic [7:0]  OFS_FULL_CHG     = 8'h12;
   localparam logic [7:0]  OFS_AVG_CUR      = 8'h14;
   localparam logic [7:0]  OFS_TO_EMPTY     = 8'h16;
   localparam logic [7:0]  OFS_TO_FULL      = 8'h18;
   localparam logic [7:0]  OFS_STBY_CUR     = 8'h1A;
   localparam logic [7:0]  OFS_STBY_RUN     = 8'h1C;
   localparam logic [7:0]  OFS_PEAK_CUR     = 8'h1E;
   localparam logic [7:0]  OFS_PEAK_RUN     = 8'h20;
   localparam logic [7:0]  OFS_ENERGY       = 8'h22;
   localparam logic [7:0]  OFS_AVG_PWR      = 8'h24;
   localparam logic [7:0]  OFS_CP_RUN       = 8'h26;
   localparam logic [7:0]  OFS_RESERVED     = 8'h28;
   localparam logic [7:0]  OFS_CYCLES       = 8'h2A;
   localparam logic [7:0]  OFS_PERCENT      = 8'h2C;

   // Reset and fill values
   localparam logic [15:0] RESERVED_VALUE   = 16'h0000;
   localparam logic [15:0] CTRL_RESET       = 16'h0000;
   localparam logic [15:0] RATE_RESET       = 16'h0000;

   // Control subcommands handled here
   localparam logic [15:0] SUB_STATUS       = 16'h0000;
   localparam logic [15:0] SUB_SET_HIB      = 16'h0011;
   localparam logic [15:0] SUB_CLR_HIB      = 16'h0012;
   localparam logic [15:0] SUB_LOCK         = 16'h0020;

   // Status word bit positions
   localparam int          CS_LOCKED_BIT    = 13;
   localparam int          CS_HIB_BIT       = 6;
   localparam int          CS_SLEEP_BIT     = 4;

   // User flash geometry
   localparam int          FLASH_BLK_BYTES  = 32;
   localparam int          FLASH_BYTES      = 64;

   // Serial engine states
   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_ACK_ADDR,
      S_WR,
      S_ACK_WR,
      S_RD,
      S_ACK_RD
   } gscm_bus_state_t;

   // Power modes
   typedef enum logic [1:0] {
      PM_NORMAL,
      PM_SLEEP,
      PM_HIBERNATE,
      PM_INSERT_PROBE
   } gscm_pmode_t;

   // Measurement words supplied by the gauging logic
   typedef struct packed {
      logic [15:0] setpoint_runtime_min;
      logic [15:0] temp_external;
      logic [15:0] temp_internal;
      logic [15:0] cell_voltage_mv;
      logic [15:0] gauge_flag_word;
      logic [15:0] nominal_avail_capacity;
      logic [15:0] full_avail_capacity;
      logic [15:0] remaining_charge_mah;
      logic [15:0] full_charge_mah;
      logic [15:0] avg_current_ma;
      logic [15:0] runtime_to_empty_min;
      logic [15:0] runtime_to_full_min;
      logic [15:0] standby_current_ma;
      logic [15:0] standby_runtime_min;
      logic [15:0] peak_load_current_ma;
      logic [15:0] peak_load_runtime_min;
      logic [15:0] stored_energy_mwh;
      logic [15:0] avg_power_mw;
      logic [15:0] const_power_runtime_min;
      logic [15:0] charge_cycle_total;
      logic [15:0] charge_percent;
   } gscm_meas_t;

   // User flash access port request
   typedef struct packed {
      logic        wr;
      logic        blk;
      logic [4:0]  offset;
      logic [7:0]  wdata;
   } gscm_flash_req_t;

   // Whole state of the block
   typedef struct packed {
      logic [2:0]                 scl_sync;
      logic [2:0]                 sda_sync;
      gscm_bus_state_t            st;
      logic [3:0]                 bitcnt;
      logic [7:0]                 shreg;
      logic [7:0]                 ptr;
      logic                       rw;
      logic                       nack;
      logic                       first;
      logic [7:0]                 lo_stage;
      logic                       sda_drv;
      logic [15:0]                control_word;
      logic [15:0]                rate_setpoint_ma;
      logic                       open_access_mode;
      gscm_pmode_t                pmode;
      logic                       hib_req;
      logic [FLASH_BYTES-1:0][7:0] flash;
      logic [7:0]                 flash_rdata;
   } gscm_state_t;

endpackage

// ---- core/gscm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module gscm_top
(
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      nrst,
   // Serial bus pins
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output logic                           sda_out,
   output logic                           sda_oe,
   // Gauging logic side
   input  wire gscm_pkg::gscm_meas_t      meas,
   input  wire logic                      temp_internal_sel,
   input  wire logic                      sleep_cond,
   input  wire logic                      battery_present,
   input  wire logic                      open_grant,
   // User flash port
   input  wire gscm_pkg::gscm_flash_req_t flash_req,
   output logic [7:0]                     flash_rdata,
   // Status
   output gscm_pkg::gscm_pmode_t          power_mode,
   output logic                           open_access_mode,
   output logic [15:0]                    control_word
);
   import gscm_pkg::*;

   gscm_state_t s_ff;
   gscm_state_t nxt_s;
   logic        scl_r;
   logic        scl_p;
   logic        sda_r;
   logic        sda_p;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic [15:0] rd_word;
   logic [7:0]  rd_byte;
   logic [15:0] status_word;
   logic [15:0] temp_word;
   logic [7:0]  word_ofs;

   // Bit 0 is the first synchroniser stage; only bit 1 reads it
   assign scl_r    = s_ff.scl_sync[1];
   assign scl_p    = s_ff.scl_sync[2];
   assign sda_r    = s_ff.sda_sync[1];
   assign sda_p    = s_ff.sda_sync[2];
   assign scl_rise = scl_r & ~scl_p;
   assign scl_fall = ~scl_r & scl_p;
   assign start_c  = scl_r & scl_p & sda_p & ~sda_r;
   assign stop_c   = scl_r & scl_p & ~sda_p & sda_r;

   // Temperature source select
   assign temp_word = temp_internal_sel ? meas.temp_internal
                                        : meas.temp_external;

   // Status word returned when the status subcommand is selected
   always_comb
   begin
      status_word = '0;
      status_word[CS_LOCKED_BIT] = ~s_ff.open_access_mode;
      status_word[CS_HIB_BIT]    = s_ff.hib_req;
      status_word[CS_SLEEP_BIT]  = (s_ff.pmode == PM_SLEEP);
   end

   // Word read mux on the even code of each pair
   assign word_ofs = {s_ff.ptr[7:1], 1'b0};
   always_comb
   begin
      case (word_ofs)
         OFS_CONTROL:    rd_word = (s_ff.control_word == SUB_STATUS) ?
                                   status_word : s_ff.control_word;
         OFS_RATE:       rd_word = s_ff.rate_setpoint_ma;
         OFS_RATE_RUN:   rd_word = meas.setpoint_runtime_min;
         OFS_TEMP:       rd_word = temp_word;
         OFS_VOLT:       rd_word = meas.cell_voltage_mv;
         OFS_FLAGS:      rd_word = meas.gauge_flag_word;
         OFS_NOM_CAP:    rd_word = meas.nominal_avail_capacity;
         OFS_FULL_AVAIL: rd_word = meas.full_avail_capacity;
         OFS_REMAIN:     rd_word = meas.remaining_charge_mah;
         OFS_FULL_CHG:   rd_word = meas.full_charge_mah;
         OFS_AVG_CUR:    rd_word = meas.avg_current_ma;
         OFS_TO_EMPTY:   rd_word = meas.runtime_to_empty_min;
         OFS_TO_FULL:    rd_word = meas.runtime_to_full_min;
         OFS_STBY_CUR:   rd_word = meas.standby_current_ma;
         OFS_STBY_RUN:   rd_word = meas.standby_runtime_min;
         OFS_PEAK_CUR:   rd_word = meas.peak_load_current_ma;
         OFS_PEAK_RUN:   rd_word = meas.peak_load_runtime_min;
         OFS_ENERGY:     rd_word = meas.stored_energy_mwh;
         OFS_AVG_PWR:    rd_word = meas.avg_power_mw;
         OFS_CP_RUN:     rd_word = meas.const_power_runtime_min;
         OFS_RESERVED:   rd_word = RESERVED_VALUE;
         OFS_CYCLES:     rd_word = meas.charge_cycle_total;
         OFS_PERCENT:    rd_word = meas.charge_percent;
         default:        rd_word = RESERVED_VALUE;
      endcase
   end

   // Low byte at the even code, high byte at the odd code
   assign rd_byte = s_ff.ptr[0] ? rd_word[15:8] : rd_word[7:0];

   // Next-state logic: serial engine, registers, power mode, flash
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.scl_sync = {s_ff.scl_sync[1:0], scl_in};
      nxt_s.sda_sync = {s_ff.sda_sync[1:0], sda_in};

      // Serial engine
      if (start_c)
      begin
         nxt_s.st      = S_ADDR;
         nxt_s.bitcnt  = '0;
         nxt_s.sda_drv = 1'b0;
      end
      else if (stop_c)
      begin
         nxt_s.st      = S_IDLE;
         nxt_s.sda_drv = 1'b0;
      end
      else
      begin
         case (s_ff.st)
            S_IDLE:
            begin
               nxt_s.sda_drv = 1'b0;
            end

            S_ADDR, S_WR:
            begin
               if (scl_rise)
               begin
                  nxt_s.shreg  = {s_ff.shreg[6:0], sda_r};
                  nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
               end
               else if (scl_fall && s_ff.bitcnt == BITS_PER_BYTE)
               begin
                  if (s_ff.st == S_ADDR)
                  begin
                     if (s_ff.shreg[7:1] == SLAVE_ADDR)
                     begin
                        nxt_s.sda_drv = 1'b1;
                        nxt_s.rw      = s_ff.shreg[0];
                        nxt_s.st      = S_ACK_ADDR;
                        // Addressing wakes the gauge to serve commands
                        if (s_ff.pmode == PM_SLEEP ||
                            s_ff.pmode == PM_HIBERNATE)
                        begin
                           nxt_s.pmode   = PM_NORMAL;
                           nxt_s.hib_req = 1'b0;
                        end
                     end
                     else
                        nxt_s.st = S_IDLE;
                  end
                  else
                  begin
                     nxt_s.sda_drv = 1'b1;
                     nxt_s.st      = S_ACK_WR;
                     if (s_ff.first)
                     begin
                        nxt_s.ptr   = s_ff.shreg;
                        nxt_s.first = 1'b0;
                     end
                     else
                     begin
                        nxt_s.ptr = s_ff.ptr + 8'h01;
                        if (!s_ff.ptr[0])
                           nxt_s.lo_stage = s_ff.shreg;
                        else if (word_ofs == OFS_CONTROL)
                        begin
                           // Control is writable in both modes
                           nxt_s.control_word = {s_ff.shreg,
                                                 s_ff.lo_stage};
                           if ({s_ff.shreg, s_ff.lo_stage} == SUB_CLR_HIB)
                           begin
                              nxt_s.hib_req = 1'b0;
                              if (s_ff.pmode == PM_HIBERNATE)
                                 nxt_s.pmode = PM_NORMAL;
                           end
                           if ({s_ff.shreg, s_ff.lo_stage} == SUB_SET_HIB)
                              nxt_s.hib_req = 1'b1;
                           if ({s_ff.shreg, s_ff.lo_stage} == SUB_LOCK)
                              nxt_s.open_access_mode = 1'b0;
                        end
                        else if (word_ofs == OFS_RATE &&
                                 s_ff.open_access_mode)
                           nxt_s.rate_setpoint_ma = {s_ff.shreg,
                                                     s_ff.lo_stage};
                        // Any other code keeps its value
                     end
                  end
               end
            end

            S_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  nxt_s.bitcnt = '0;
                  if (s_ff.rw)
                  begin
                     nxt_s.shreg   = rd_byte;
                     nxt_s.sda_drv = ~rd_byte[7];
                     nxt_s.st      = S_RD;
                  end
                  else
                  begin
                     nxt_s.sda_drv = 1'b0;
                     nxt_s.first   = 1'b1;
                     nxt_s.st      = S_WR;
                  end
               end
            end

            S_ACK_WR:
            begin
               if (scl_fall)
               begin
                  nxt_s.sda_drv = 1'b0;
                  nxt_s.bitcnt  = '0;
                  nxt_s.st      = S_WR;
               end
            end

            S_RD:
            begin
               if (scl_rise)
                  nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
               else if (scl_fall)
               begin
                  if (s_ff.bitcnt == BITS_PER_BYTE)
                  begin
                     nxt_s.sda_drv = 1'b0;
                     nxt_s.ptr     = s_ff.ptr + 8'h01;
                     nxt_s.st      = S_ACK_RD;
                  end
                  else
                  begin
                     nxt_s.shreg   = {s_ff.shreg[6:0], 1'b0};
                     nxt_s.sda_drv = ~s_ff.shreg[6];
                  end
               end
            end

            S_ACK_RD:
            begin
               if (scl_rise)
                  nxt_s.nack = sda_r;
               else if (scl_fall)
               begin
                  nxt_s.bitcnt = '0;
                  if (s_ff.nack)
                  begin
                     nxt_s.sda_drv = 1'b0;
                     nxt_s.st      = S_IDLE;
                  end
                  else
                  begin
                     // Spooling continues with the next code
                     nxt_s.shreg   = rd_byte;
                     nxt_s.sda_drv = ~rd_byte[7];
                     nxt_s.st      = S_RD;
                  end
               end
            end

            default:
            begin
               nxt_s.st      = S_IDLE;
               nxt_s.sda_drv = 1'b0;
            end
         endcase
      end

      // Access opening from the unlock logic; set wins over a lock
      if (open_grant)
         nxt_s.open_access_mode = 1'b1;

      // Autonomous power mode moves
      case (s_ff.pmode)
         PM_NORMAL:
         begin
            if (!battery_present)
               nxt_s.pmode = PM_INSERT_PROBE;
            else if (sleep_cond && nxt_s.pmode == PM_NORMAL)
               nxt_s.pmode = PM_SLEEP;
         end

         PM_SLEEP:
         begin
            if (!battery_present)
               nxt_s.pmode = PM_INSERT_PROBE;
            else if (s_ff.hib_req && nxt_s.pmode == PM_SLEEP)
               nxt_s.pmode = PM_HIBERNATE;
            else if (!sleep_cond)
               nxt_s.pmode = PM_NORMAL;
         end

         PM_HIBERNATE:
         begin
            if (!battery_present)
               nxt_s.pmode = PM_INSERT_PROBE;
         end

         PM_INSERT_PROBE:
         begin
            if (battery_present)
               nxt_s.pmode = PM_NORMAL;
         end

         default:
            nxt_s.pmode = PM_NORMAL;
      endcase

      // User flash port: reads always, writes only when opened
      nxt_s.flash_rdata = s_ff.flash[{flash_req.blk, flash_req.offset}];
      if (flash_req.wr && s_ff.open_access_mode)
         nxt_s.flash[{flash_req.blk, flash_req.offset}] = flash_req.wdata;
   end

   // State register
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   // Outputs from flops, except sda_out which is tied low
   assign sda_out          = 1'b0;
   assign sda_oe           = s_ff.sda_drv;
   assign flash_rdata      = s_ff.flash_rdata;
   assign power_mode       = s_ff.pmode;
   assign open_access_mode = s_ff.open_access_mode;
   assign control_word     = s_ff.control_word;

endmodule // gscm_top
`default_nettype wire

// ---- tb/gscm_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module gscm_chk
(
   // Clock and reset
   input wire logic                      core_clk,
   input wire logic                      nrst,
   // Pins and side inputs
   input wire logic                      scl_in,
   input wire logic                      sda_out,
   input wire logic                      sda_oe,
   input wire logic                      sleep_cond,
   input wire logic                      battery_present,
   input wire logic                      open_grant,
   input wire gscm_pkg::gscm_flash_req_t flash_req,
   // Outputs watched
   input wire logic [7:0]                flash_rdata,
   input wire gscm_pkg::gscm_pmode_t     power_mode,
   input wire logic                      open_access_mode
);
   import gscm_pkg::*;
   logic [5:0] fa;
   // Flash address of the current request
   assign fa = {flash_req.blk, flash_req.offset};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_drain; sda_out == 1'b0; endproperty
   a_drain: assert property (p_drain)
      else $error("sda_out driven high");
   property p_oe_scl; $changed(sda_oe) |-> !scl_in; endproperty
   a_oe_scl: assert property (p_oe_scl)
      else $error("sda_oe moved while scl high");
   property p_fl_wr;
      flash_req.wr && open_access_mode ##1 !flash_req.wr && $stable(fa)
      |=> flash_rdata == $past(flash_req.wdata, 2);
   endproperty
   a_fl_wr: assert property (p_fl_wr)
      else $error("open flash write not read back");
   property p_fl_lock;
      !flash_req.wr ##1 flash_req.wr && !open_access_mode && $stable(fa)
      ##1 !flash_req.wr && $stable(fa) |=> flash_rdata == $past(flash_rdata, 2);
   endproperty
   a_fl_lock: assert property (p_fl_lock)
      else $error("locked flash write took effect");
   property p_open; open_grant |-> ##[1:2] open_access_mode; endproperty
   a_open: assert property (p_open)
      else $error("open grant ignored");
   property p_open_cause; $rose(open_access_mode) |-> $past(open_grant); endproperty
   a_open_cause: assert property (p_open_cause)
      else $error("access opened without grant");
   property p_sleep_cause;
      $rose(power_mode == PM_SLEEP) |-> $past(sleep_cond) || $past(sleep_cond, 2);
   endproperty
   a_sleep_cause: assert property (p_sleep_cause)
      else $error("sleep entered without cause");
   property p_probe;
      $fell(battery_present) |-> ##[1:8] power_mode == PM_INSERT_PROBE;
   endproperty
   a_probe: assert property (p_probe)
      else $error("battery removal not probed");
   // Main scenarios reached
   c_open: cover property (open_grant);
   c_ack: cover property ($rose(sda_oe));
   c_sleep: cover property (power_mode == PM_SLEEP);
endmodule // gscm_chk
bind gscm_top gscm_chk u_chk (.core_clk, .nrst, .scl_in, .sda_out, .sda_oe,
   .sleep_cond, .battery_present, .open_grant, .flash_req, .flash_rdata,
   .power_mode, .open_access_mode);
`default_nettype wire

// ---- tb/gscm_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module gscm_host
(
   // Clock and bus level
   input  wire logic core_clk,
   input  wire logic sda,
   // Bus drive, idle high and released
   output logic      scl,
   output logic      sda_pull
);
   import gscm_pkg::*;
   localparam int Q = 6;
   // Idle bus at time zero
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Third of a bus clock on falling edges
   task automatic tick();
      repeat (Q) @(negedge core_clk);
   endtask
   // Start or repeated start
   task automatic start();
      sda_pull = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_pull = 1'b1;
      tick();
      scl = 1'b0;
      tick();
   endtask
   // Stop, leaves the clock standing high
   task automatic stop();
      sda_pull = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      sda_pull = 1'b0;
      tick();
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic rel,
                       output logic [7:0] q, output logic ack);
      logic [8:0] v;
      logic [8:0] r;
      v = {d, rel};
      r = '0;
      for (int i = 8; i >= 0; i--)
      begin
         sda_pull = ~v[i];
         tick();
         scl = 1'b1;
         tick();
         r = {r[7:0], sda};
         scl = 1'b0;
         tick();
      end
      q = r[8:1];
      ack = ~r[0];
   endtask
   // Code transaction, then the word, low byte first
   task automatic wr16(input logic [7:0] c, input logic [15:0] w,
                       output logic ok);
      logic [7:0] q;
      logic [3:0] a;
      start();
      xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, a[0]);
      xfer(c, 1'b1, q, a[1]);
      xfer(w[7:0], 1'b1, q, a[2]);
      xfer(w[15:8], 1'b1, q, a[3]);
      stop();
      ok = &a;
   endtask
   // Code, repeated start, two bytes with final not-acknowledge
   task automatic rd16(input logic [7:0] c, output logic [15:0] w,
                       output logic ok);
      logic [3:0] a;
      start();
      xfer({SLAVE_ADDR, 1'b0}, 1'b1, w[7:0], a[0]);
      xfer(c, 1'b1, w[7:0], a[1]);
      start();
      xfer({SLAVE_ADDR, 1'b1}, 1'b1, w[7:0], a[2]);
      xfer(8'hFF, 1'b0, w[7:0], a[3]);
      xfer(8'hFF, 1'b1, w[15:8], a[3]);
      stop();
      ok = &a[2:0];
   endtask
endmodule // gscm_host
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import gscm_pkg::*;
   typedef struct packed {logic [7:0] code; logic [15:0] word;} gscm_row_t;
   localparam logic [15:0] ST_LOCK = 16'h0001 << CS_LOCKED_BIT;
   localparam logic [15:0] ST_HIB  = 16'h0001 << CS_HIB_BIT;
   logic            core_clk;
   logic            nrst;
   logic            scl;
   logic            sda_pull;
   wire             sda;
   logic            sda_out;
   logic            sda_oe;
   gscm_meas_t      meas;
   logic            temp_internal_sel;
   logic            sleep_cond;
   logic            battery_present;
   logic            open_grant;
   gscm_flash_req_t flash_req;
   logic [7:0]      flash_rdata;
   gscm_pmode_t     power_mode;
   logic            open_access_mode;
   logic [15:0]     control_word;
   gscm_row_t       rows [21];
   int              miscompares;
   int              check_count;
   int              cycles;
   logic [15:0]     w;
   logic [7:0]      q;
   logic            ok;
   // Open-drain data line with pull-up
   assign sda = ~(sda_pull | (sda_oe & ~sda_out));
   gscm_top dut (.core_clk, .nrst, .scl_in(scl), .sda_in(sda), .sda_out,
      .sda_oe, .meas, .temp_internal_sel, .sleep_cond, .battery_present,
      .open_grant, .flash_req, .flash_rdata, .power_mode, .open_access_mode,
      .control_word);
   gscm_host host (.core_clk, .sda, .scl, .sda_pull);
   // Core clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Cycle ceiling against a hung bus
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   function automatic logic [15:0] fval(input int k);
      return {8'h80 + k[7:0], 8'h40 + k[7:0]};
   endfunction
   // Measurement word expected at a command code
   function automatic logic [15:0] exp_of(input logic [7:0] c);
      if (c == OFS_RESERVED) return RESERVED_VALUE;
      if (c == OFS_RATE_RUN) return fval(0);
      if (c == OFS_TEMP) return fval(1);
      if (c == OFS_VOLT) return fval(3);
      if (c < OFS_RESERVED) return fval(int'(c - OFS_FLAGS) / 2 + 4);
      return fval(int'(c - OFS_CYCLES) / 2 + 19);
   endfunction
   task automatic rdc(input logic [7:0] c, input logic [15:0] e);
      host.rd16(c, w, ok);
      check(ok, 1'b1);
      check(w, e);
   endtask
   task automatic wrc(input logic [7:0] c, input logic [15:0] v);
      host.wr16(c, v, ok);
      check(ok, 1'b1);
   endtask
   task automatic fx(input logic wr, input logic b, input logic [4:0] o,
                     input logic [7:0] d);
      flash_req = '{wr, b, o, d};
      @(negedge core_clk);
   endtask
   task automatic wait_mode(input gscm_pmode_t m);
      for (int i = 0; i < 50 && power_mode !== m; i++)
         @(negedge core_clk);
      check(power_mode, m);
   endtask
   // Main sequence
   initial
   begin
      nrst = 1'b0;
      meas = '0;
      temp_internal_sel = 1'b0;
      sleep_cond = 1'b0;
      battery_present = 1'b1;
      open_grant = 1'b0;
      flash_req = '0;
      for (int k = 0; k < 21; k++)
         meas[(20-k)*16 +: 16] = fval(k);
      for (int i = 0; i < 21; i++)
         rows[i] = '{8'(4 + 2*i), exp_of(8'(4 + 2*i))};
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
      check({open_access_mode, power_mode, sda_oe, control_word},
            {1'b0, PM_NORMAL, 1'b0, CTRL_RESET});
      foreach (rows[i])
         rdc(rows[i].code, rows[i].word);
      rdc(OFS_CONTROL, ST_LOCK);
      temp_internal_sel = 1'b1;
      rdc(OFS_TEMP, fval(2));
      rdc(8'h40, RESERVED_VALUE);
      host.start();
      host.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ok);
      host.stop();
      check(ok, 1'b0);
      wrc(OFS_RATE, 16'h1234);
      rdc(OFS_RATE, RATE_RESET);
      wrc(OFS_VOLT, 16'hFFFF);
      rdc(OFS_VOLT, fval(3));
      // Lone low byte of the control word
      host.start();
      host.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, ok);
      host.xfer(OFS_CONTROL, 1'b1, q, ok);
      host.xfer(8'hAB, 1'b1, q, ok);
      host.stop();
      check(control_word, CTRL_RESET);
      wrc(OFS_CONTROL, SUB_SET_HIB);
      check(control_word, SUB_SET_HIB);
      rdc(OFS_CONTROL, SUB_SET_HIB);
      wrc(OFS_CONTROL, SUB_STATUS);
      rdc(OFS_CONTROL, ST_LOCK | ST_HIB);
      wrc(OFS_CONTROL, SUB_CLR_HIB);
      wrc(OFS_CONTROL, SUB_STATUS);
      rdc(OFS_CONTROL, ST_LOCK);
      // Flash write while locked, back to back with reads
      fx(1'b0, 1'b0, 5'h03, 8'h00);
      fx(1'b1, 1'b0, 5'h03, 8'h77);
      fx(1'b0, 1'b0, 5'h03, 8'h00);
      check(flash_rdata, 8'h00);
      open_grant = 1'b1;
      @(negedge core_clk);
      open_grant = 1'b0;
      @(negedge core_clk);
      check(open_access_mode, 1'b1);
      rdc(OFS_CONTROL, 16'h0000);
      wrc(OFS_RATE, 16'h8421);
      rdc(OFS_RATE, 16'h8421);
      // Top byte of both blocks
      fx(1'b1, 1'b1, 5'h1F, 8'hA5);
      fx(1'b0, 1'b1, 5'h1F, 8'h00);
      check(flash_rdata, 8'hA5);
      fx(1'b1, 1'b0, 5'h1F, 8'h5A);
      fx(1'b0, 1'b0, 5'h1F, 8'h00);
      check(flash_rdata, 8'h5A);
      fx(1'b0, 1'b1, 5'h1F, 8'h00);
      check(flash_rdata, 8'hA5);
      wrc(OFS_CONTROL, SUB_LOCK);
      check(open_access_mode, 1'b0);
      wrc(OFS_RATE, 16'h1111);
      rdc(OFS_RATE, 16'h8421);
      sleep_cond = 1'b1;
      wait_mode(PM_SLEEP);
      wrc(OFS_CONTROL, SUB_SET_HIB);
      wait_mode(PM_HIBERNATE);
      sleep_cond = 1'b0;
      rdc(OFS_PERCENT, fval(20));
      check(power_mode, PM_NORMAL);
      battery_present = 1'b0;
      wait_mode(PM_INSERT_PROBE);
      @(negedge core_clk);
      final_report();
   end
endmodule // testbench
`default_nettype wire
